/* rtl/gp_pin_function_settings.sv */
`timescale 1ns/1ps
// What this block does
// - Load nonvolatile image into working copy.
// - Working-copy writes act on pins immediately.
// - Designation change re-routes the pin.
// - Nonvolatile edits never reach the pins; reset restores the factory image.
// - Four bytes, index 0-3, pins 0-3.
// - Bit 4 is general output level.
// - Bit 3 direction, one means input.
// - Code 000 selects general I/O everywhere.
// - Pin 0: suspend indicator, receive LED.
// - Pin 1: clock, ADC, transmit LED, interrupt.
// - Pin 2: configured indicator, ADC, DAC.
// - Pin 3: two-wire LED, ADC, DAC.
// - Factory defaults with output high.
// - Suspend indicator low during suspend.
// - Configured indicator low until configured, suspend.
module gp_pin_function_settings (
	input wire logic clock,
	input wire logic resetn,
	input wire logic reqValid,
	input wire gpfs_pkg::gpfs_req_s req,
	output logic [7:0] readData,
	output logic readValid,
	input wire gpfs_pkg::gpfs_func_s func,
	input wire logic [3:0] padIn,
	output logic [3:0] padOut,
	output logic [3:0] padOe,
	output logic [3:0] padInValue,
	output logic [3:0] analogSelect,
	output logic [3:0] irqSelect,
	output logic loadDone
);
	import gpfs_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************

	// All state of the block in one record.
	typedef struct packed {
		logic [3:0][7:0] nv;
		logic [3:0][7:0] work;
		logic loaded;
		logic [7:0] rdata;
		logic rvalid;
		logic [3:0] padOut;
		logic [3:0] padOe;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] anaSel;
		logic [3:0] irqSel;
	} gpfs_state_s;

	gpfs_state_s state_ff;
	gpfs_state_s nxt_state;
	logic [3:0] cellOut;
	logic [3:0] cellOe;
	logic [3:0] cellAna;
	logic [3:0] cellIrq;

	// ****************************************************************
	// Pin cells
	// ****************************************************************

	// One mux per pin, fed straight from the working copy.
	generate
		for (genvar i = 0; i < GPFS_PINS; i++) begin : g_pin
			gpfs_pin_cell #(.PIN(i)) u_cell (
				.cfg(gpfs_cfg_s'(state_ff.work[i])),
				.gpioLevel(state_ff.work[i][LEVEL_BIT]),
				.func(func),
				.padOut(cellOut[i]),
				.padOe(cellOe[i]),
				.analogSel(cellAna[i]),
				.irqSel(cellIrq[i])
			);
		end
	endgenerate

	// ****************************************************************
	// Next state
	// ****************************************************************

	// Register access, load of the working copy and pin registers.
	always_comb begin
		nxt_state = state_ff;
		nxt_state.rvalid = 1'b0;
		nxt_state.sync1 = padIn;
		nxt_state.sync2 = state_ff.sync1;
		// The image is copied once after reset.
		if (!state_ff.loaded) begin
			nxt_state.work = state_ff.nv;
			nxt_state.loaded = 1'b1;
		end else if (reqValid) begin
			if (req.writeEn) begin
				// Reserved bits are dropped so they read as zero.
				if (req.nvSelect) begin
					nxt_state.nv[req.index] = req.data & CFG_WRITE_MASK;
				end else begin
					nxt_state.work[req.index] = req.data & CFG_WRITE_MASK;
				end
			end else begin
				nxt_state.rvalid = 1'b1;
				nxt_state.rdata = req.nvSelect ? state_ff.nv[req.index] :
					state_ff.work[req.index];
			end
		end
		// Pins are released until the working copy is valid.
		nxt_state.padOut = state_ff.loaded ? cellOut : 4'h0;
		nxt_state.padOe = state_ff.loaded ? cellOe : 4'h0;
		nxt_state.anaSel = state_ff.loaded ? cellAna : 4'h0;
		nxt_state.irqSel = state_ff.loaded ? cellIrq : 4'h0;
	end

	// State register; the image is held but reset to factory values.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_ff <= '0;
			state_ff.nv <= {PIN3_DEFAULT, PIN2_DEFAULT,
				PIN1_DEFAULT, PIN0_DEFAULT};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign padOut = state_ff.padOut;
	assign padOe = state_ff.padOe;
	assign padInValue = state_ff.sync2;
	assign analogSelect = state_ff.anaSel;
	assign irqSelect = state_ff.irqSel;
	assign readData = state_ff.rdata;
	assign readValid = state_ff.rvalid;
	assign loadDone = state_ff.loaded;

	// ****************************************************************
	// Checks
	// ****************************************************************

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	load_copy_a: assert property (!loadDone |=>
		state_ff.work == $past(state_ff.nv))
		else $error("working copy not loaded from image");
	work_write_a: assert property (loadDone && reqValid &&
		req.writeEn && !req.nvSelect |=>
		state_ff.work[$past(req.index)] ==
		($past(req.data) & CFG_WRITE_MASK))
		else $error("working write not applied");
	nv_isolated_a: assert property (loadDone && reqValid &&
		req.nvSelect |=> $stable(state_ff.work))
		else $error("image write changed working copy");
	gpio_dir_a: assert property (loadDone &&
		state_ff.work[0][2:0] == DES_GPIO |=>
		padOe[0] == ~$past(state_ff.work[0][DIR_BIT]))
		else $error("direction wrong on pin 0");
	gpio_level_a: assert property (loadDone &&
		state_ff.work[1][3:0] == 4'h0 |=>
		padOut[1] == $past(state_ff.work[1][LEVEL_BIT]))
		else $error("output level wrong on pin 1");
	reserved_hiz_a: assert property (loadDone &&
		state_ff.work[3][2:0] > DES_ALT1 |=> !padOe[3])
		else $error("reserved code drives pin 3");
	suspend_low_a: assert property (loadDone &&
		state_ff.work[0][2:0] == DES_DEDICATED && func.usbSuspended |=>
		padOe[0] && !padOut[0])
		else $error("suspend indicator not low");
	cfg_low_a: assert property (loadDone &&
		state_ff.work[2][2:0] == DES_DEDICATED && !func.usbConfigured |=>
		!padOut[2])
		else $error("configured indicator high too early");
	// Back-to-back reads are legal, so a second pulse may follow at once.
	read_pulse_a: assert property (loadDone && reqValid &&
		!req.writeEn |=> readValid ##1
		(!readValid || $past(reqValid && !req.writeEn)))
		else $error("read answer not a single pulse");

endmodule // gp_pin_function_settings

/* pkg/gpfs_pkg.sv */
// ****************************************************************
// Shared constants and types for the pin function settings block.
// ****************************************************************
package gpfs_pkg;

	// Number of general-purpose pins and bytes in the settings map.
	localparam int GPFS_PINS = 4;

	// Byte index of each pin's settings byte.
	localparam logic [1:0] PIN0_FUNCTION_CONFIG_OFS = 2'h0;
	localparam logic [1:0] PIN1_FUNCTION_CONFIG_OFS = 2'h1;
	localparam logic [1:0] PIN2_FUNCTION_CONFIG_OFS = 2'h2;
	localparam logic [1:0] PIN3_FUNCTION_CONFIG_OFS = 2'h3;

	// Field positions inside a settings byte.
	localparam int LEVEL_BIT = 4;
	localparam int DIR_BIT = 3;
	localparam int DES_LSB = 0;
	localparam int DES_MSB = 2;

	// Designation codes.
	localparam logic [2:0] DES_GPIO = 3'h0;
	localparam logic [2:0] DES_DEDICATED = 3'h1;
	localparam logic [2:0] DES_ALT0 = 3'h2;
	localparam logic [2:0] DES_ALT1 = 3'h3;
	localparam logic [2:0] DES_ALT2 = 3'h4;

	// Mask of writable bits; the top three are reserved.
	localparam logic [7:0] CFG_WRITE_MASK = 8'h1F;

	// Factory default bytes: level high, direction output.
	localparam logic [7:0] PIN0_DEFAULT = 8'h12;
	localparam logic [7:0] PIN1_DEFAULT = 8'h13;
	localparam logic [7:0] PIN2_DEFAULT = 8'h11;
	localparam logic [7:0] PIN3_DEFAULT = 8'h11;

	// One pin's settings byte.
	typedef struct packed {
		logic [2:0] reserved;
		logic defaultOutputLevel;
		logic ioDirection;
		logic [2:0] pinDesignation;
	} gpfs_cfg_s;

	// Register access request: one write or read per strobe.
	typedef struct packed {
		logic writeEn;
		logic nvSelect;
		logic [1:0] index;
		logic [7:0] data;
	} gpfs_req_s;

	// Signals arriving from the alternate-function cores.
	typedef struct packed {
		logic usbSuspended;
		logic usbConfigured;
		logic receiveActivityLed;
		logic transmitActivityLed;
		logic twoWireActivityLed;
		logic clockReference;
		logic dacOut;
	} gpfs_func_s;

endpackage

/* rtl/gpfs_pin_cell.sv */
`timescale 1ns/1ps
// ****************************************************************
// One pin's output selection from its working settings byte.
// ****************************************************************
module gpfs_pin_cell #(
	parameter int PIN = 0
) (
	input wire gpfs_pkg::gpfs_cfg_s cfg,
	input wire logic gpioLevel,
	input wire gpfs_pkg::gpfs_func_s func,
	output logic padOut,
	output logic padOe,
	output logic analogSel,
	output logic irqSel
);
	import gpfs_pkg::*;

	// Only four pins exist; any other index has no function table.
	if (PIN < 0 || PIN >= GPFS_PINS) begin : g_bad_pin
		$error("pin cell index out of range");
	end

	// Purely combinational so that a new byte routes the pin at once.
	always_comb begin
		padOut = 1'b0;
		padOe = 1'b0;
		analogSel = 1'b0;
		irqSel = 1'b0;
		if (cfg.pinDesignation == DES_GPIO) begin
			padOe = ~cfg.ioDirection;
			padOut = gpioLevel;
		end else begin
			case (PIN)
				0: begin
					padOe = (cfg.pinDesignation == DES_DEDICATED) ||
						(cfg.pinDesignation == DES_ALT0);
					padOut = (cfg.pinDesignation == DES_DEDICATED) ?
						~func.usbSuspended : func.receiveActivityLed;
				end
				1: begin
					padOe = (cfg.pinDesignation == DES_DEDICATED) ||
						(cfg.pinDesignation == DES_ALT1);
					padOut = (cfg.pinDesignation == DES_DEDICATED) ?
						func.clockReference : func.transmitActivityLed;
					analogSel = cfg.pinDesignation == DES_ALT0;
					irqSel = cfg.pinDesignation == DES_ALT2;
				end
				2: begin
					padOe = cfg.pinDesignation == DES_DEDICATED;
					padOut = func.usbConfigured & ~func.usbSuspended;
					analogSel = (cfg.pinDesignation == DES_ALT0) ||
						(cfg.pinDesignation == DES_ALT1);
				end
				default: begin
					padOe = cfg.pinDesignation == DES_DEDICATED;
					padOut = func.twoWireActivityLed;
					analogSel = (cfg.pinDesignation == DES_ALT0) ||
						(cfg.pinDesignation == DES_ALT1);
				end
			endcase
			// Reserved codes fall through with the pad released.
		end
	end

endmodule // gpfs_pin_cell

/* dv/gpfs_ext_pins.sv */
`timescale 1ns/1ps
// ****************************************************************
// Circuit outside the four pins.
// ****************************************************************
module gpfs_ext_pins (
	input wire logic [3:0] padOut,
	input wire logic [3:0] padOe,
	input wire logic [3:0] extDrive,
	output logic [3:0] padIn
);
	// The device wins while it drives; elsewhere the outside level shows.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			padIn[i] = padOe[i] ? padOut[i] : extDrive[i];
		end
	end
endmodule // gpfs_ext_pins

/* dv/gpfs_testbench.sv */
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the pin function settings block.
// ****************************************************************
module testbench;
	import gpfs_pkg::*;
	logic clock, resetn, reqValid, readValid, loadDone;
	gpfs_req_s req;
	gpfs_func_s func;
	logic [7:0] readData;
	logic [3:0] padIn, padOut, padOe, padInValue, analogSelect, irqSelect;
	logic [3:0] extDrive;
	int n_fail, comparisons;
	// Pin, code, then expected {drive, level, analog, irq}.
	logic [11:0] tbl [16] = '{12'h01C, 12'h02C, 12'h030, 12'h11C,
		12'h122, 12'h13C, 12'h141, 12'h150, 12'h21C, 12'h222, 12'h232,
		12'h240, 12'h31C, 12'h322, 12'h332, 12'h370};
	gp_pin_function_settings dut (.clock(clock), .resetn(resetn),
		.reqValid(reqValid), .req(req), .readData(readData),
		.readValid(readValid), .func(func), .padIn(padIn),
		.padOut(padOut), .padOe(padOe), .padInValue(padInValue),
		.analogSelect(analogSelect), .irqSelect(irqSelect),
		.loadDone(loadDone));
	gpfs_ext_pins ext (.padOut(padOut), .padOe(padOe),
		.extDrive(extDrive), .padIn(padIn));
	// ****************************************************************
	// Clock, access tasks and comparison.
	// ****************************************************************
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// One strobe; inputs change 1 ns after the edge to avoid races.
	task access(input logic w, nv, input logic [1:0] i, input logic [7:0] d);
		@(posedge clock);
		#1 reqValid = 1'b1;
		req = '{w, nv, i, d};
		@(posedge clock);
		#1 reqValid = 1'b0;
	endtask
	task chk(input string what, input logic [7:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// The answer stands one cycle only; access returns inside that cycle.
	task rd(input logic nv, input logic [1:0] i, input logic [7:0] exp);
		access(1'b0, nv, i, 8'h00);
		chk("readValid", 8'h01, {7'h00, readValid});
		chk("readData", exp, readData);
	endtask
	task settle;
		repeat (2) @(posedge clock);
		#1;
	endtask
	// Level is only meaningful while the pin drives.
	task pin(input logic [1:0] i, input logic [3:0] exp);
		chk("pin", {4'h0, exp}, {4'h0, padOe[i], padOe[i] & padOut[i],
			analogSelect[i], irqSelect[i]});
	endtask
	task complete_run;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Generous span: the tests need well under 1000 cycles.
	initial begin
		#20000;
		n_fail++;
		complete_run();
	end
	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		reqValid = 1'b0;
		req = '0;
		func = '0;
		extDrive = 4'h0;
		n_fail = 0;
		comparisons = 0;
		resetn = 1'b0;
		repeat (3) @(posedge clock);
		#1 resetn = 1'b1;
		settle();
		chk("loadDone", 8'h01, {7'h00, loadDone});
		rd(1'b0, 2'h0, 8'h12);
		rd(1'b0, 2'h1, 8'h13);
		rd(1'b0, 2'h2, 8'h11);
		rd(1'b0, 2'h3, 8'h11);
		pin(2'h2, 4'h8);
		func = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		settle();
		pin(2'h0, 4'hC);
		for (int k = 0; k < 4; k++) begin
			access(1'b1, 1'b0, k[1:0], 8'h10);
			settle();
			pin(k[1:0], 4'hC);
			access(1'b1, 1'b0, k[1:0], 8'h00);
			settle();
			pin(k[1:0], 4'h8);
			access(1'b1, 1'b0, k[1:0], 8'h18);
			extDrive[k] = 1'b1;
			repeat (4) @(posedge clock);
			#1 pin(k[1:0], 4'h0);
			chk("padInValue", 8'h01, {7'h00, padInValue[k]});
		end
		for (int k = 0; k < 16; k++) begin
			access(1'b1, 1'b0, tbl[k][9:8], {5'h02, tbl[k][6:4]});
			settle();
			pin(tbl[k][9:8], tbl[k][3:0]);
		end
		access(1'b1, 1'b0, 2'h0, 8'h11);
		access(1'b1, 1'b0, 2'h2, 8'h11);
		settle();
		pin(2'h2, 4'hC);
		func.usbSuspended = 1'b1;
		settle();
		pin(2'h0, 4'h8);
		pin(2'h2, 4'h8);
		func.usbSuspended = 1'b0;
		settle();
		pin(2'h0, 4'hC);
		pin(2'h2, 4'hC);
		func.usbConfigured = 1'b0;
		settle();
		pin(2'h2, 4'h8);
		access(1'b1, 1'b0, 2'h3, 8'hF1);
		rd(1'b0, 2'h3, 8'h11);
		access(1'b1, 1'b1, 2'h3, 8'h08);
		settle();
		pin(2'h3, 4'hC);
		rd(1'b0, 2'h3, 8'h11);
		rd(1'b1, 2'h3, 8'h08);
		complete_run();
	end
endmodule // testbench
